// [rtl/charger_pin_regs.svh]
// Behaviour
// - outside the startup mode, while the boost request pin is active and not disabled by software the block asserts boost operation.
// - the pin outranks the software boost bit unless software has disabled the pin.
// - after reset, while the 15-minute mode lasts, the pin selects input current limit.
// - during that startup mode the programmed input current limit is ignored.
// - in the startup role a low pin selects the 100 mA limit.
// - while the unlock pin is low the safety limits sit at default and writes are dropped.
// - while the unlock pin is high the safety register takes writes until a write to the control or limit register locks it.
// - the status pin is pulled low while charging or during a fault pulse, and released otherwise.
// - a fault makes the status pin emit one 128 us low pulse.
// - with status enable cleared the status pin stays released.
`ifndef CHARGER_PIN_REGS_SVH
`define CHARGER_PIN_REGS_SVH

// register indices
`define ADDR_CONTROL 3'h0
`define ADDR_LIMIT 3'h1
`define ADDR_SAFETY 3'h2
`define ADDR_STATUS 3'h3

// control field positions
`define CTRL_BOOST_BIT 0
`define CTRL_PIN_DIS_BIT 1
`define CTRL_STAT_EN_BIT 2
`define CTRL_MODE_EXIT_BIT 3
`define CTRL_RESET 8'h04

// safety default and limit codes
`define SAFETY_RESET 8'h00
`define LIMIT_RESET 2'h0
`define ILIM_100MA 2'h0
`define ILIM_500MA 2'h1

// timing
`define CLOCK_MHZ 100
`define FAULT_PULSE_US 128
`define FAULT_PULSE_CYCLES (`FAULT_PULSE_US * `CLOCK_MHZ)
`define STARTUP_MINUTES 15
`define US_PER_MINUTE 64'h0000_0000_0393_8700
// 64-bit product: fifteen minutes of clock cycles does not fit a 32-bit int
`define STARTUP_MODE_CYCLES (`US_PER_MINUTE * `STARTUP_MINUTES * `CLOCK_MHZ)

`endif

// [rtl/charger_pin_pkg.sv]
package charger_pin_pkg;
    typedef enum logic [1:0] {
        STAT_IDLE,
        STAT_PULSE
    } stat_state_t;
endpackage

// [rtl/fault_pulse_timer.sv]
`timescale 1ns/1ps
`default_nettype none
`include "charger_pin_regs.svh"
// one-shot pulse generator for fault reporting
module fault_pulse_timer #(
    parameter int CYCLES = `FAULT_PULSE_CYCLES
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic trigger,
    output logic active
);
    localparam int W = $clog2(CYCLES + 1);
    charger_pin_pkg::stat_state_t state_q, state_d;
    logic [W-1:0] count_q, count_d;

    // start on trigger, ignore triggers while running
    always_comb begin
        state_d = state_q;
        count_d = count_q;
        unique case (state_q)
            charger_pin_pkg::STAT_IDLE: begin
                if (trigger) begin
                    state_d = charger_pin_pkg::STAT_PULSE;
                    count_d = W'(CYCLES - 1);
                end
            end
            charger_pin_pkg::STAT_PULSE: begin
                if (count_q == '0) begin
                    state_d = charger_pin_pkg::STAT_IDLE;
                end else begin
                    count_d = count_q - 1'b1;
                end
            end
            default: begin
                state_d = charger_pin_pkg::STAT_IDLE;
                count_d = '0;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= charger_pin_pkg::STAT_IDLE;
            count_q <= '0;
        end else begin
            state_q <= state_d;
            count_q <= count_d;
        end
    end

    assign active = (state_q == charger_pin_pkg::STAT_PULSE);
endmodule
`default_nettype wire

// [rtl/startup_mode_timer.sv]
`timescale 1ns/1ps
`default_nettype none
`include "charger_pin_regs.svh"
// holds the startup mode for a fixed count after reset unless software exits it
module startup_mode_timer #(
    parameter longint CYCLES = `STARTUP_MODE_CYCLES
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic exit_req,
    output logic active
);
    localparam int W = $clog2(CYCLES + 1);
    logic [W-1:0] count_q, count_d;
    logic active_q, active_d;

    // count down from reset; leave mode at zero or on request
    always_comb begin
        count_d = count_q;
        active_d = active_q;
        if (active_q) begin
            if (exit_req || count_q == '0) begin
                active_d = 1'b0;
            end else begin
                count_d = count_q - 1'b1;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            count_q <= W'(CYCLES - 1);
            active_q <= 1'b1;
        end else begin
            count_q <= count_d;
            active_q <= active_d;
        end
    end

    assign active = active_q;
endmodule
`default_nettype wire

// [rtl/charger_pin_control.sv]
// Local design decisions: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "charger_pin_regs.svh"
// pin-level control of the charger: boost request, safety limit lock, status pin
module charger_pin_control #(
    parameter int FAULT_CYCLES = `FAULT_PULSE_CYCLES,
    parameter longint STARTUP_CYCLES = `STARTUP_MODE_CYCLES
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rdata,
    input wire logic boost_request_pin,
    input wire logic safety_limit_unlock_pin,
    input wire logic charging,
    input wire logic fault,
    output logic boost_en,
    output logic [1:0] input_limit_sel,
    output logic [7:0] safety_limit,
    output logic stat_out,
    output logic stat_oe
);
    logic [7:0] ctrl_q, ctrl_d;
    logic [1:0] limit_q, limit_d;
    logic [7:0] safety_q, safety_d;
    logic locked_q, locked_d;
    logic fault_q;
    logic fault_rise;
    logic pulse_active;
    logic startup;
    logic boost_q, boost_d;
    logic [1:0] ilim_q, ilim_d;
    logic oe_q, oe_d;
    logic [7:0] rdata_q, rdata_d;
    logic exit_req;

    assign exit_req = wr_en && addr == `ADDR_CONTROL && wdata[`CTRL_MODE_EXIT_BIT];
    assign fault_rise = fault && !fault_q;

    // startup mode lasts 15 minutes from reset
    startup_mode_timer #(
        .CYCLES(STARTUP_CYCLES)
    ) u_startup (
        .clock(clock),
        .rst_b(rst_b),
        .exit_req(exit_req),
        .active(startup)
    );

    // fixed-width pulse on each new fault while no pulse is running
    fault_pulse_timer #(
        .CYCLES(FAULT_CYCLES)
    ) u_fault (
        .clock(clock),
        .rst_b(rst_b),
        .trigger(fault_rise),
        .active(pulse_active)
    );

    // register writes and safety lock
    always_comb begin
        ctrl_d = ctrl_q;
        limit_d = limit_q;
        safety_d = safety_q;
        locked_d = locked_q;
        if (!safety_limit_unlock_pin) begin
            safety_d = `SAFETY_RESET;
            locked_d = 1'b0;
        end
        if (wr_en) begin
            unique case (addr)
                `ADDR_CONTROL: begin
                    ctrl_d = wdata;
                    locked_d = 1'b1;
                end
                `ADDR_LIMIT: begin
                    limit_d = wdata[1:0];
                    locked_d = 1'b1;
                end
                `ADDR_SAFETY: begin
                    if (safety_limit_unlock_pin && !locked_q) begin
                        safety_d = wdata;
                    end
                end
                default: begin
                end
            endcase
            if (!safety_limit_unlock_pin) begin
                locked_d = 1'b0;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_q <= `CTRL_RESET;
            limit_q <= `LIMIT_RESET;
            safety_q <= `SAFETY_RESET;
            locked_q <= 1'b0;
            fault_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            limit_q <= limit_d;
            safety_q <= safety_d;
            locked_q <= locked_d;
            fault_q <= fault;
        end
    end

    // boost, current limit and status pin decisions
    always_comb begin
        if (startup) begin
            boost_d = 1'b0;
            ilim_d = boost_request_pin ? `ILIM_500MA : `ILIM_100MA;
        end else begin
            ilim_d = limit_q;
            if (!ctrl_q[`CTRL_PIN_DIS_BIT] && boost_request_pin) begin
                boost_d = 1'b1;
            end else begin
                boost_d = ctrl_q[`CTRL_BOOST_BIT];
            end
        end
        if (!ctrl_q[`CTRL_STAT_EN_BIT]) begin
            oe_d = 1'b0;
        end else if (pulse_active || fault_rise) begin
            oe_d = 1'b1;
        end else begin
            oe_d = charging;
        end
    end

    // read mux
    always_comb begin
        rdata_d = 8'h00;
        if (rd_en) begin
            unique case (addr)
                `ADDR_CONTROL: rdata_d = ctrl_q;
                `ADDR_LIMIT: rdata_d = {6'h00, limit_q};
                `ADDR_SAFETY: rdata_d = safety_q;
                `ADDR_STATUS: rdata_d = {3'h0, pulse_active, locked_q, startup, boost_q, oe_q};
                default: rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            boost_q <= 1'b0;
            ilim_q <= `ILIM_100MA;
            oe_q <= 1'b0;
            rdata_q <= 8'h00;
        end else begin
            boost_q <= boost_d;
            ilim_q <= ilim_d;
            oe_q <= oe_d;
            rdata_q <= rdata_d;
        end
    end

    assign boost_en = boost_q;
    assign input_limit_sel = ilim_q;
    assign safety_limit = safety_q;
    assign stat_oe = oe_q;
    assign stat_out = 1'b0;
    assign rdata = rdata_q;
endmodule
`default_nettype wire

// [verification/charger_pin_control_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module charger_pin_control_asserts (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] rdata,
    input wire logic boost_request_pin,
    input wire logic safety_limit_unlock_pin,
    input wire logic charging,
    input wire logic fault,
    input wire logic boost_en,
    input wire logic [1:0] input_limit_sel,
    input wire logic [7:0] safety_limit,
    input wire logic stat_out,
    input wire logic stat_oe
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    logic st_q, dis_q, sw_q, en_q, lk_q;
    // mirror of control bits and safety lock, taken from bus writes
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            {st_q, en_q, dis_q, sw_q, lk_q} <= 5'b11000;
        end else begin
            if (wr_en && addr == 3'h0) begin
                {st_q, en_q, dis_q, sw_q} <= {st_q & ~wdata[3], wdata[2:0]};
            end
            lk_q <= safety_limit_unlock_pin & (lk_q | (wr_en & addr < 3'h2));
        end
    end
    AST_BOOST_PIN: assert property (boost_request_pin && !dis_q && !st_q |=> boost_en)
        else $error("boost pin ignored");
    AST_BOOST_IDLE: assert property (!boost_request_pin && !sw_q |=> !boost_en)
        else $error("boost without cause");
    AST_BOOST_START: assert property (st_q |=> !boost_en)
        else $error("boost in startup");
    // rst_b in the antecedent keeps the release edge, where outputs still sit in reset, out
    AST_LIMIT_PIN: assert property (rst_b && st_q |=> input_limit_sel == {1'b0, $past(boost_request_pin)})
        else $error("startup limit wrong");
    AST_SAFE_DEFAULT: assert property (!safety_limit_unlock_pin |=> safety_limit == 8'h00)
        else $error("safety not default");
    AST_SAFE_WRITE: assert property (safety_limit_unlock_pin && !lk_q && wr_en && addr == 3'h2 |=> safety_limit == $past(wdata))
        else $error("safety write lost");
    AST_SAFE_LOCK: assert property (safety_limit_unlock_pin && lk_q |=> $stable(safety_limit))
        else $error("locked safety changed");
    AST_STAT_CHARGE: assert property (charging && en_q |=> stat_oe)
        else $error("status not low while charging");
    AST_STAT_OFF: assert property (!en_q |=> !stat_oe)
        else $error("status driven while disabled");
    AST_FAULT_PULSE: assert property ($rose(fault) && en_q && !stat_oe && !charging |=> stat_oe [*8] ##1 stat_oe ##1 !stat_oe)
        else $error("fault pulse width wrong");
    cover property ($rose(fault) && stat_oe);
    cover property (lk_q && wr_en && addr == 3'h2);
    cover property (boost_en && sw_q && !boost_request_pin);
endmodule
bind charger_pin_control charger_pin_control_asserts chk_u (.*);
`default_nettype wire

// [verification/host_pin_model.sv]
`timescale 1ns/1ps
`default_nettype none
module host_pin_model (
    input wire logic clock,
    input wire logic want_boost,
    input wire logic want_unlock,
    input wire logic stat_out,
    input wire logic stat_oe,
    output logic boost_request_pin,
    output logic safety_limit_unlock_pin,
    output logic stat_level
);
    // host gpio pins, low until the first edge
    initial {boost_request_pin, safety_limit_unlock_pin} = 2'b00;
    always @(posedge clock) begin
        boost_request_pin <= want_boost;
        safety_limit_unlock_pin <= want_unlock;
    end
    // pull-up on the open-drain status line
    assign stat_level = stat_oe ? stat_out : 1'b1;
endmodule
`default_nettype wire

// [verification/tb_charger_pin_control.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_charger_pin_control;
    logic clock, rst_b, wr_en, rd_en, rd_d, charging, fault, stat_out, stat_oe, boost_en;
    logic want_boost, want_unlock, boost_request_pin, safety_limit_unlock_pin, stat_level;
    logic [2:0] addr;
    logic [7:0] wdata, rdata, safety_limit, r;
    logic [1:0] input_limit_sel;
    logic [7:0] exp_q[$];
    int fails, checks_done, cyc;
    charger_pin_control #(.FAULT_CYCLES(8), .STARTUP_CYCLES(50)) dut_u (.*);
    host_pin_model host_u (.*);
    // clock
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // read-valid delay and hang guard
    always @(posedge clock) begin
        rd_d <= rd_en;
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fails++;
            final_report();
        end
    end
    // oldest expectation against read data in its valid cycle
    always @(negedge clock) begin
        if (rd_d === 1'b1) begin
            checks_done++;
            if (rdata !== exp_q[0]) begin
                fails++;
                $display("FAIL %0t got %h exp %h", $time, rdata, exp_q[0]);
            end
            void'(exp_q.pop_front());
        end
    end
    task automatic op(input logic w, input logic [2:0] a, input logic [7:0] d);
        @(posedge clock);
        wr_en <= w;
        rd_en <= 1'b0;
        addr <= a;
        wdata <= d;
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        @(posedge clock);
        wr_en <= 1'b0;
        rd_en <= 1'b1;
        addr <= a;
        exp_q.push_back(e);
    endtask
    // immediate level compare, called half a cycle after the launching edge
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checks_done++;
        if (g !== e) begin
            fails++;
            $display("FAIL %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) op(1'b0, 3'h0, 8'h00);
    endtask
    task automatic final_report();
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        {rst_b, wr_en, rd_en, charging, fault, want_boost, want_unlock, cyc} = '0;
        want_boost = 1'b1;
        addr = 3'h0;
        wdata = 8'h00;
        void'($urandom(61));
        r = 8'($urandom);
        repeat (8) @(posedge clock);
        rst_b <= 1'b1;
        rd(3'h3, 8'h04);
        op(1'b1, 3'h1, 8'h00);
        want_boost <= 1'b0;
        op(1'b1, 3'h2, 8'h5a);
        @(negedge clock);
        chk({6'h00, input_limit_sel}, 8'h01);
        rd(3'h2, 8'h00);
        want_unlock <= 1'b1;
        @(negedge clock);
        chk({6'h00, input_limit_sel}, 8'h00);
        wt(2);
        op(1'b1, 3'h2, r);
        rd(3'h2, r);
        op(1'b1, 3'h0, 8'h0c);
        op(1'b1, 3'h2, ~r);
        rd(3'h2, r);
        rd(3'h3, 8'h08);
        want_boost <= 1'b1;
        wt(3);
        rd(3'h3, 8'h0a);
        @(negedge clock);
        chk({6'h00, input_limit_sel}, 8'h00);
        op(1'b1, 3'h0, 8'h06);
        wt(2);
        rd(3'h3, 8'h08);
        want_boost <= 1'b0;
        op(1'b1, 3'h0, 8'h05);
        wt(3);
        rd(3'h3, 8'h0a);
        op(1'b1, 3'h0, 8'h04);
        charging <= 1'b1;
        wt(2);
        rd(3'h3, 8'h09);
        charging <= 1'b0;
        @(negedge clock);
        chk({7'h00, stat_level}, 8'h00);
        wt(2);
        fault <= 1'b1;
        wt(3);
        rd(3'h3, 8'h19);
        fault <= 1'b0;
        wt(1);
        fault <= 1'b1;
        wt(15);
        op(1'b1, 3'h0, 8'h00);
        fault <= 1'b0;
        wt(1);
        fault <= 1'b1;
        wt(2);
        rd(3'h3, 8'h18);
        @(negedge clock);
        chk({7'h00, stat_level}, 8'h01);
        rd(3'h5, 8'h00);
        want_unlock <= 1'b0;
        wt(3);
        rd(3'h2, 8'h00);
        wt(2);
        final_report();
    end
endmodule
`default_nettype wire
